// ===== src/ish_pkg.sv
package ish_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 200;
  localparam int XTAL_PERIOD_NS = 50;
  localparam int RST_MIN_XTAL   = 10;
  localparam int POR_NS         = RST_MIN_XTAL * XTAL_PERIOD_NS;
  localparam int POR_CYCLES     = (POR_NS * CLK_MHZ + 999) / 1000;
  localparam int PROM_ACC_NS    = 200;
  localparam int PROM_CYCLES    = (PROM_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 8;

  // ****************************************
  // Address decode
  // ****************************************
  localparam int IO_WIN_BITS  = 5;
  localparam int APROM_BITS   = 4;
  localparam int DEC_BITS     = 10;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] SD_RST   = 16'h0000;
  localparam logic [1:0]  LANE_OFF = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        rst_sys;
    logic        aen;
    logic        ior_n;
    logic        iow_n;
    logic        memr_n;
    logic        memw_n;
    logic        refresh;
    logic        sbhe_n;
    logic        boot_rom_addr_match_n;
    logic [15:0] sa;
    logic [15:0] sd;
    logic [7:0]  prdb;
  } ish_pins_t;

  typedef struct packed {
    logic babble_flag;
    logic missed_frame_flag;
    logic memory_error_flag;
    logic receive_irq_flag;
    logic init_done_flag;
    logic transmit_start_flag;
  } ish_flags_t;

  typedef enum logic [1:0] {
    ACC_REG_RD,
    ACC_REG_WR,
    ACC_APROM,
    ACC_BOOT
  } ish_acc_t;

endpackage

// ===== src/ish_sync.sv
`timescale 1ns/1ps
module ish_sync
  import ish_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ===== src/ish_host_if.sv
`timescale 1ns/1ps
// Overview of operation
// - Ready goes high only once read data is valid or write data captured.
// - An I/O address outside the first sixteen bytes of the window, with enable low and no strobe needed, pulls the 16-bit chip select low.
// - 16-bit chip select decodes only low ten address lines and enable.
// - Configuration bit 0 cleared forces 8-bit-only I/O, no 16-bit select.
// - Read strobe is a slave read only with enable low and address match.
// - Write strobe is a slave write only with enable low and address match.
// - Interrupt asserts when any of six status flags is set.
// - A set mask bit keeps its flag from raising the interrupt.
// - Low memory-read strobe is a read cycle, low memory-write a write.
// - Memory-read strobe is ignored while refresh is active.
// - Reset input high resets the device and deasserts every output but in_reset_o, which goes high.
// - Device resets itself at power-up with no external pulse.
// - Only 8-bit transfers until a falling edge on byte-high enable.
// - Device drives data on slave reads and captures it on slave writes.
// - I/O read in first sixteen bytes of the window selects address PROM.
// - Address PROM data goes to the low byte, 16-bit select stays off.
// - Boot match plus memory read selects boot PROM, data buffered, no 16-bit.
module ish_host_if
  import ish_pkg::*;
(
  // Clock and power-up reset
  input  wire logic                 mclk_i,
  input  wire logic                 reset_n_i,
  // Bus pins (asynchronous)
  input  wire ish_pins_t            pins_i,
  // Configuration
  input  wire logic [DEC_BITS-1:0]  io_base_i,
  input  wire logic                 cfg_io16_i,
  input  wire ish_flags_t           flags_i,
  input  wire ish_flags_t           mask_i,
  // Core register side
  input  wire logic [15:0]          reg_rdata_i,
  input  wire logic                 reg_ack_i,
  output logic                      reg_rd_o,
  output logic                      reg_wr_o,
  output logic [IO_WIN_BITS-1:0]    reg_addr_o,
  output logic [15:0]               reg_wdata_o,
  output logic                      reg_wide_o,
  // Bus outputs
  output logic                      iochrdy_oe_o,
  output logic                      iocs16_oe_o,
  output logic [15:0]               sd_o,
  output logic [1:0]                sd_oe_o,
  output logic                      irq_o,
  output logic                      mem_rd_cyc_o,
  output logic                      mem_wr_cyc_o,
  // Board outputs
  output logic                      addr_prom_select_n_o,
  output logic                      boot_rom_select_n_o,
  output logic                      in_reset_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_HOLD
  } ish_state_t;

  // ****************************************
  // Synchronised pins
  // ****************************************
  ish_pins_t b;

  ish_sync #(
    .W($bits(ish_pins_t))
  ) u_sync (
    .mclk_i   (mclk_i),
    .reset_n_i(reset_n_i),
    .async_i  (pins_i),
    .sync_o   (b)
  );

  // ****************************************
  // Internal reset
  // ****************************************
  logic [CNT_W-1:0] por_q;
  logic             rst_q;
  wire  logic       por_busy = (por_q != CNT_W'(POR_CYCLES));

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      por_q <= '0;
      rst_q <= 1'b1;
    end else begin
      por_q <= por_busy ? por_q + CNT_W'(1) : por_q;
      rst_q <= por_busy | b.rst_sys;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  wire logic io_hit   = !b.aen &&
                        (b.sa[DEC_BITS-1:IO_WIN_BITS] ==
                         io_base_i[DEC_BITS-1:IO_WIN_BITS]);
  wire logic aprom_hit = (b.sa[IO_WIN_BITS-1:APROM_BITS] == '0);
  wire logic io_rd    = io_hit && !b.ior_n;
  wire logic io_wr    = io_hit && !b.iow_n;
  wire logic mem_rd   = !b.memr_n && !b.refresh;
  wire logic boot_rd  = mem_rd && !b.boot_rom_addr_match_n;
  wire logic strobes  = !b.ior_n || !b.iow_n || mem_rd;

  logic sbhe_prev_q;
  logic sbhe_seen_q;
  wire  logic sbhe_fall = sbhe_prev_q && !b.sbhe_n;
  wire  logic wide_ok   = cfg_io16_i && sbhe_seen_q;
  wire  logic wide_acc  = wide_ok && !b.sbhe_n;
  wire  logic cs16_d    = io_hit && !aprom_hit && wide_ok;

  wire  logic irq_d     = |(flags_i & ~mask_i);

  // ****************************************
  // Access sequencer
  // ****************************************
  ish_state_t       st_q;
  ish_acc_t         kind_q;
  logic [CNT_W-1:0] wait_q;
  logic             wide_q;

  wire logic prom_acc  = (kind_q == ACC_APROM) || (kind_q == ACC_BOOT);
  wire logic acc_done  = prom_acc ? (wait_q == '0) : reg_ack_i;
  wire logic is_read   = (kind_q != ACC_REG_WR);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sbhe_prev_q <= 1'b1;
      sbhe_seen_q <= 1'b0;
    end else if (rst_q) begin
      sbhe_prev_q <= 1'b1;
      sbhe_seen_q <= 1'b0;
    end else begin
      sbhe_prev_q <= b.sbhe_n;
      sbhe_seen_q <= sbhe_seen_q | sbhe_fall;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q                 <= ST_IDLE;
      kind_q               <= ACC_REG_RD;
      wait_q               <= '0;
      wide_q               <= 1'b0;
      reg_rd_o             <= 1'b0;
      reg_wr_o             <= 1'b0;
      reg_addr_o           <= '0;
      reg_wdata_o          <= SD_RST;
      reg_wide_o           <= 1'b0;
      iochrdy_oe_o         <= 1'b0;
      sd_o                 <= SD_RST;
      sd_oe_o              <= LANE_OFF;
      addr_prom_select_n_o <= 1'b1;
      boot_rom_select_n_o  <= 1'b1;
    end else if (rst_q) begin
      st_q                 <= ST_IDLE;
      kind_q               <= ACC_REG_RD;
      wait_q               <= '0;
      wide_q               <= 1'b0;
      reg_rd_o             <= 1'b0;
      reg_wr_o             <= 1'b0;
      reg_addr_o           <= '0;
      reg_wdata_o          <= SD_RST;
      reg_wide_o           <= 1'b0;
      iochrdy_oe_o         <= 1'b0;
      sd_o                 <= SD_RST;
      sd_oe_o              <= LANE_OFF;
      addr_prom_select_n_o <= 1'b1;
      boot_rom_select_n_o  <= 1'b1;
    end else begin
      reg_rd_o <= 1'b0;
      reg_wr_o <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          wait_q <= CNT_W'(PROM_CYCLES);
          wide_q <= wide_acc;
          if (io_rd || io_wr || boot_rd) begin
            st_q         <= ST_WAIT;
            iochrdy_oe_o <= 1'b1;
            reg_addr_o   <= b.sa[IO_WIN_BITS-1:0];
            reg_wide_o   <= wide_acc;
          end
          if (io_rd && aprom_hit) begin
            kind_q               <= ACC_APROM;
            addr_prom_select_n_o <= 1'b0;
          end else if (io_rd) begin
            kind_q   <= ACC_REG_RD;
            reg_rd_o <= 1'b1;
          end else if (io_wr) begin
            kind_q      <= ACC_REG_WR;
            reg_wr_o    <= 1'b1;
            reg_wdata_o <= {wide_acc ? b.sd[15:8] : 8'h00, b.sd[7:0]};
          end else if (boot_rd) begin
            kind_q              <= ACC_BOOT;
            boot_rom_select_n_o <= 1'b0;
          end
        end
        ST_WAIT: begin
          wait_q <= (wait_q != '0) ? wait_q - CNT_W'(1) : wait_q;
          if (acc_done) begin
            st_q         <= ST_HOLD;
            iochrdy_oe_o <= 1'b0;
            if (prom_acc) begin
              sd_o    <= {8'h00, b.prdb};
              sd_oe_o <= 2'h1;
            end else if (is_read) begin
              sd_o    <= reg_rdata_i;
              sd_oe_o <= {wide_q, 1'b1};
            end
          end
        end
        ST_HOLD: begin
          if (!strobes) begin
            st_q                 <= ST_IDLE;
            sd_oe_o              <= LANE_OFF;
            addr_prom_select_n_o <= 1'b1;
            boot_rom_select_n_o  <= 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      iocs16_oe_o  <= 1'b0;
      irq_o        <= 1'b0;
      mem_rd_cyc_o <= 1'b0;
      mem_wr_cyc_o <= 1'b0;
      in_reset_o   <= 1'b1;
    end else begin
      iocs16_oe_o  <= !rst_q && cs16_d;
      irq_o        <= !rst_q && irq_d;
      mem_rd_cyc_o <= !rst_q && mem_rd;
      mem_wr_cyc_o <= !rst_q && !b.memw_n;
      in_reset_o   <= rst_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_irq_follows_flags: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !rst_q && (|(flags_i & ~mask_i)) |=> irq_o)
    else $error("interrupt not raised by unmasked flag");

  a_irq_mask_blocks: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    ((flags_i & ~mask_i) == '0) |=> !irq_o)
    else $error("interrupt raised with all flags masked");

  a_read_qualified: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    reg_rd_o |-> $past(!b.aen && !b.ior_n && io_hit && !aprom_hit))
    else $error("register read without qualified strobe");

  a_write_qualified: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    reg_wr_o |-> $past(!b.aen && !b.iow_n && io_hit))
    else $error("register write without qualified strobe");

  a_ready_after_data: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    $fell(iochrdy_oe_o) && is_read && !rst_q |-> sd_oe_o[0])
    else $error("ready released before read data driven");

  a_cs16_decode: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    iocs16_oe_o |-> $past(io_hit && !aprom_hit && cfg_io16_i && sbhe_seen_q))
    else $error("16-bit select without address decode");

  a_eight_bit_only: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !sbhe_seen_q |-> !sd_oe_o[1] ##1 !iocs16_oe_o)
    else $error("16-bit transfer before byte-high edge");

  a_refresh_masks: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    b.refresh |=> !$fell(boot_rom_select_n_o) && !mem_rd_cyc_o)
    else $error("memory read honoured during refresh");

  a_prom_wait_rdy: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    $fell(addr_prom_select_n_o) && !rst_q |-> iochrdy_oe_o [*8])
    else $error("ready released during prom access");

  a_reset_quiet: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    rst_q |=> !iochrdy_oe_o && (sd_oe_o == LANE_OFF) && !irq_o
              && addr_prom_select_n_o && boot_rom_select_n_o)
    else $error("output active during reset");

  a_mem_write_cycle: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !b.memw_n && !rst_q |=> mem_wr_cyc_o)
    else $error("memory write cycle not flagged");

  a_mem_read_cycle: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !b.memr_n && !b.refresh && !rst_q |=> mem_rd_cyc_o)
    else $error("memory read cycle not flagged");

  a_write_capture: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    reg_wr_o |-> (reg_wdata_o[7:0] == $past(b.sd[7:0])))
    else $error("write data not captured from bus");

  a_aprom_select: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !rst_q && (st_q == ST_IDLE) && io_rd && aprom_hit |=> !addr_prom_select_n_o)
    else $error("address prom not selected");

  a_boot_select: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !rst_q && (st_q == ST_IDLE) && boot_rd && !io_rd && !io_wr |=> !boot_rom_select_n_o)
    else $error("boot prom not selected");

  a_prom_low_lane: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    !addr_prom_select_n_o |-> !sd_oe_o[1])
    else $error("high byte driven during prom read");

  a_write_no_drive: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    (kind_q == ACC_REG_WR) && (st_q != ST_IDLE) |-> (sd_oe_o == LANE_OFF))
    else $error("data bus driven during write");

endmodule

// ===== testbench/ish_core_model.sv
`timescale 1ns/1ps
module ish_core_model
  import ish_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   reset_n_i,
  // Requests from the host interface
  input  wire logic                   rd_i,
  input  wire logic                   wr_i,
  input  wire logic [IO_WIN_BITS-1:0] addr_i,
  input  wire logic [15:0]            wdata_i,
  input  wire logic [2:0]             lat_i,
  // Answer
  output logic      [15:0]            rdata_o,
  output logic                        ack_o
);
  logic [15:0]            mem_q [32];
  logic [15:0]            last_q;
  logic [2:0]             cnt_q;
  logic [IO_WIN_BITS-1:0] a_q;

  // Ack after a programmable wait, data valid only with ack
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q  <= 3'h0;
      ack_o  <= 1'b0;
      last_q <= 16'h0000;
      a_q    <= '0;
    end else begin
      ack_o <= (cnt_q == 3'h1);
      if (rd_i | wr_i) begin
        cnt_q <= lat_i + 3'h1;
        a_q   <= addr_i;
        if (wr_i) mem_q[addr_i] <= wdata_i;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
      if (ack_o) last_q <= rdata_o;
    end
  end

  // Outside ack the data lines show no stale value
  assign rdata_o = ack_o ? mem_q[a_q] : ~last_q;
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  import ish_pkg::*;
  logic mclk_i = 0, reset_n_i = 0, cfg_io16 = 1, ack, rd, wr, wide, rdy_oe, cs16_oe, irq;
  logic mrd_cyc, mwr_cyc, psel_n, bsel_n, in_rst, psel, bsel, mrd;
  logic [15:0] rdata, wdata, sd, rdat;
  logic [1:0] sd_oe, roe;
  logic [4:0] addr;
  logic [2:0] lat = 0;
  ish_pins_t pins;
  ish_flags_t flags = '0, mask = '0;
  int miscompares = 0, samples_checked = 0, n;

  always #2.5 mclk_i = ~mclk_i;

  ish_host_if ish_host_if_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .pins_i(pins),
    .io_base_i(10'h300), .cfg_io16_i(cfg_io16), .flags_i(flags), .mask_i(mask),
    .reg_rdata_i(rdata), .reg_ack_i(ack), .reg_rd_o(rd), .reg_wr_o(wr), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wide_o(wide), .iochrdy_oe_o(rdy_oe), .iocs16_oe_o(cs16_oe),
    .sd_o(sd), .sd_oe_o(sd_oe), .irq_o(irq), .mem_rd_cyc_o(mrd_cyc), .mem_wr_cyc_o(mwr_cyc),
    .addr_prom_select_n_o(psel_n), .boot_rom_select_n_o(bsel_n), .in_reset_o(in_rst));

  ish_core_model ish_core_model_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .rd_i(rd),
    .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .lat_i(lat), .rdata_o(rdata), .ack_o(ack));

  task automatic wt(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic idle();
    pins = '{rst_sys: 1'b0, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1, memr_n: 1'b1,
             memw_n: 1'b1, refresh: 1'b0, sbhe_n: pins.sbhe_n, boot_rom_addr_match_n: 1'b1,
             sa: 16'h0000, sd: 16'h0000, prdb: 8'h5a};
  endtask

  // One host cycle: strobe held until ready released
  task automatic acc(input logic is_rd, input logic is_mem, input logic [15:0] a,
                     input logic [15:0] d);
    pins.sa = a;
    pins.sd = d;
    pins.aen = 1'b0;
    wt(1);
    if (is_mem) pins.memr_n = 1'b0;
    else if (is_rd) pins.ior_n = 1'b0;
    else pins.iow_n = 1'b0;
    n = 0;
    while (rdy_oe !== 1'b1 && n < 50) begin wt(1); n++; end
    `CHK("ready taken", 1'b1, rdy_oe)
    {psel, bsel, mrd} = 3'h0;
    n = 0;
    while (rdy_oe === 1'b1 && n < 200) begin
      psel |= !psel_n;
      bsel |= !bsel_n;
      mrd |= mrd_cyc;
      wt(1);
      n++;
    end
    rdat = sd;
    roe = sd_oe;
    idle();
    wt(1);
    while (sd_oe !== 2'h0 && n < 250) begin wt(1); n++; end
    `CHK("bus released", 2'h0, sd_oe)
    wt(1);
  endtask

  initial begin
    pins.sbhe_n = 1'b1;
    idle();
    wt(4);
    `CHK("reset state", 1'b1, in_rst)
    `CHK("ready in reset", 1'b0, rdy_oe)
    #1 reset_n_i = 1;
    n = 0;
    while (in_rst !== 1'b0 && n < 300) begin wt(1); n++; end
    `CHK("power-up done", 1'b0, in_rst)
    `CHK("selects off", 2'h3, {psel_n, bsel_n})
    acc(0, 0, 16'h0312, 16'hbeef);
    acc(1, 0, 16'h0312, 16'h0000);
    `CHK("read low byte", 8'hef, rdat[7:0])
    `CHK("8-bit lanes", 2'h1, roe)
    pins.sbhe_n = 1'b0;
    lat = 3'h5;
    wt(4);
    acc(0, 0, 16'h0312, 16'hbeef);
    acc(1, 0, 16'h0312, 16'h0000);
    `CHK("read word", 16'hbeef, rdat)
    `CHK("16-bit lanes", 2'h3, roe)
    `CHK("ready held", 1'b1, n > 5)
    pins.aen = 1'b0;
    pins.sa = 16'h0310;
    wt(4);
    `CHK("io16 decode", 1'b1, cs16_oe)
    cfg_io16 = 1'b0;
    wt(4);
    `CHK("io16 disabled", 1'b0, cs16_oe)
    cfg_io16 = 1'b1;
    pins.aen = 1'b1;
    wt(4);
    `CHK("io16 needs enable", 1'b0, cs16_oe)
    pins.sa = 16'h0305;
    pins.aen = 1'b0;
    wt(4);
    `CHK("io16 prom range", 1'b0, cs16_oe)
    pins.sa = 16'h0312;
    pins.aen = 1'b1;
    pins.ior_n = 1'b0;
    wt(10);
    `CHK("aen high ignored", 1'b0, rdy_oe)
    pins.aen = 1'b0;
    pins.sa = 16'h0212;
    wt(10);
    `CHK("read miss", 1'b0, rdy_oe)
    pins.ior_n = 1'b1;
    pins.iow_n = 1'b0;
    wt(10);
    `CHK("write miss", 1'b0, rdy_oe)
    idle();
    wt(3);
    acc(1, 0, 16'h0303, 16'h0000);
    `CHK("prom select", 1'b1, psel)
    `CHK("prom data", 8'h5a, rdat[7:0])
    `CHK("prom lanes", 2'h1, roe)
    pins.boot_rom_addr_match_n = 1'b0;
    acc(1, 1, 16'h8000, 16'h0000);
    `CHK("boot select", 2'h3, {bsel, mrd})
    `CHK("boot data", 8'h5a, rdat[7:0])
    pins.boot_rom_addr_match_n = 1'b0;
    pins.refresh = 1'b1;
    pins.memr_n = 1'b0;
    wt(10);
    `CHK("refresh masks read", 3'h4, {bsel_n, mrd_cyc, rdy_oe})
    idle();
    pins.memw_n = 1'b0;
    wt(4);
    `CHK("mem write cycle", 1'b1, mwr_cyc)
    idle();
    for (int i = 0; i < 6; i++) begin
      flags = ish_flags_t'(6'h1 << i);
      mask = '0;
      wt(4);
      `CHK("irq raised", 1'b1, irq)
      mask = flags;
      wt(4);
      `CHK("irq masked", 1'b0, irq)
    end
    mask = '0;
    pins.rst_sys = 1'b1;
    wt(100);
    `CHK("system reset", 2'h2, {in_rst, irq})
    stop_test();
  end

  initial begin
    #200us;
    miscompares++;
    stop_test();
  end
endmodule
